/* rtl/gpib_interface_glue.v */
`timescale 1ns/10ps
`default_nettype none
`include "gpib_glue_map.vh"
// Functional notes
// RL1 - measurement-done request on command raises srq per measurement; off command stops it
// RL2 - serial poll status byte carries request flag in bit 6
// RL3 - hold mode freezes the reported reading until a trigger
// RL4 - bus trigger takes a fresh reading, also in hold mode
// RL5 - sealed system strap makes power-up land in operate mode
// RL6 - sealed system bus commands select operate, dc cal or ac cal
// RL7 - transfers use ieee-488 source and acceptor handshakes inside the adapter
// RL8 - switch latch puts address and terminator bits on data bus when read
// RL9 - adapter reset held low after power-on until charge time elapses
// RL10 - cpu pulls prom enable low to fetch microprogram words
// RL11 - switch latch enabled only with read, chip select and a6 high
// RL12 - adapter enabled only with chip select and a6 low
// RL13 - adapter port chosen from a0, a1 and a5
// RL14 - read strobe forces buffer transmit enable off
// RL15 - write strobe drives buffer transmit enable on; the code drives it on only with the adapter selected and read high
// RL16 - adapter runs on the control board clock
// RL17 - data writes enable transmit toward bus, reads reverse it
module gpib_interface_glue (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] cpu_addr,
  input wire rd_n,
  input wire wr_n,
  input wire interface_chip_select_n,
  input wire prom_enable_n,
  input wire [7:0] switch_bits,
  input wire sealed_system,
  input wire meas_done,
  input wire [15:0] meas_value,
  input wire trigger_cmd,
  input wire hold_on_cmd,
  input wire hold_off_cmd,
  input wire meas_done_request_on_cmd,
  input wire meas_done_request_off_cmd,
  input wire operate_mode_cmd,
  input wire dc_cal_mode_cmd,
  input wire ac_cal_mode_cmd,
  input wire serial_poll,
  input wire [7:0] status_low,
  output wire prom_output_enable,
  output wire switch_latch_enable,
  output wire adapter_enable,
  output wire ctrl_port_sel,
  output wire data_port_sel,
  output wire buffer_transmit_enable,
  output wire adapter_reset_n,
  output wire adapter_clk,
  output reg [7:0] data_out,
  output wire data_out_en,
  output reg [7:0] status_byte,
  output reg srq,
  output reg [15:0] reading,
  output reg meas_request,
  output reg [1:0] mode
);
  // one-hot power-up sequence for the mode logic; a stray code falls back
  // to the boot state so the mode is forced to operate once more
  localparam [1:0] ST_BOOT = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;
  // decoded strobes and address fields
  wire cs;
  wire sel;
  wire [2:0] port;
  // bookkeeping flags, current and next value
  reg srq_en_q;
  reg srq_en_d;
  reg hold_q;
  reg hold_d;
  reg trig_pend_q;
  reg trig_pend_d;
  reg [1:0] pwr_state_q;
  reg [1:0] pwr_state_d;
  // mode logic next value
  reg [1:0] mode_d;
  // reading capture qualifier
  wire reading_take;
  assign cs = ~interface_chip_select_n;
  assign sel = cpu_addr[`A_BIT_SEL];
  assign port = {cpu_addr[`A_BIT_P5], cpu_addr[`A_BIT_P1], cpu_addr[`A_BIT_P0]};
  // the cpu owns this strobe; we only pass it to the prom
  // RL10 prom fetch enable
  assign prom_output_enable = ~prom_enable_n;
  // RL11 switch latch decode
  assign switch_latch_enable = ~rd_n & cs & sel;
  // RL12 adapter decode
  assign adapter_enable = cs & ~sel;
  // RL13 port select
  assign ctrl_port_sel = adapter_enable & (port == `PORT_CTRL);
  assign data_port_sel = adapter_enable & (port == `PORT_DATA);
  // RL14 RL15 RL17 direction; read wins if both strobes are low
  assign buffer_transmit_enable = adapter_enable & ~wr_n & rd_n;
  // RL16 shared clock, no separate oscillator
  assign adapter_clk = ref_clk;
  // RL7 handshake state machines live in the adapter itself
  assign data_out_en = switch_latch_enable;
  // RL9 power-on clear
  por_hold u_por (
    .ref_clk(ref_clk),
    .rst(rst),
    .adapter_reset_n(adapter_reset_n)
  );
  // RL8 switch data registered onto data bus
  always @(posedge ref_clk) begin
    if (rst) begin
      data_out <= 8'h00;
    end else if (switch_latch_enable) begin
      data_out <= switch_bits;
    end
  end
  // next values for request enable, hold mode and trigger bookkeeping;
  // on wins over off in one cycle, so a host sending both ends enabled
  always @* begin
    srq_en_d = srq_en_q;
    if (meas_done_request_on_cmd) begin
      srq_en_d = 1'b1;
    end else if (meas_done_request_off_cmd) begin
      srq_en_d = 1'b0;
    end
    hold_d = hold_q;
    if (hold_on_cmd) begin
      hold_d = 1'b1;
    end else if (hold_off_cmd) begin
      hold_d = 1'b0;
    end
    // RL4 a trigger stays pending until a measurement lands in a later cycle
    trig_pend_d = trig_pend_q;
    if (trigger_cmd) begin
      trig_pend_d = 1'b1;
    end else if (meas_done) begin
      trig_pend_d = 1'b0;
    end
  end
  // request enable, hold mode and trigger registers
  always @(posedge ref_clk) begin
    if (rst) begin
      srq_en_q <= 1'b0;
      hold_q <= 1'b0;
      trig_pend_q <= 1'b0;
      meas_request <= 1'b0;
    end else begin
      srq_en_q <= srq_en_d;
      hold_q <= hold_d;
      trig_pend_q <= trig_pend_d;
      // RL4 trigger starts a measurement pulse
      meas_request <= trigger_cmd;
    end
  end
  // RL3 RL4 a landing measurement is taken outside hold or after a trigger;
  // a trigger in the same cycle counts, so a slow host never loses a reading
  assign reading_take = meas_done & (~hold_q | trig_pend_q | trigger_cmd);
  // RL3 reading frozen in hold unless a trigger is pending or arrives in the same cycle
  always @(posedge ref_clk) begin
    if (rst) begin
      reading <= 16'h0000;
    end else if (reading_take) begin
      reading <= meas_value;
    end
  end
  // RL1 srq set per measurement; set wins over poll clear
  always @(posedge ref_clk) begin
    if (rst) begin
      srq <= 1'b0;
    end else if (meas_done & srq_en_q) begin
      srq <= 1'b1;
    end else if (serial_poll | meas_done_request_off_cmd) begin
      srq <= 1'b0;
    end
  end
  // RL2 status byte with request flag in bit 6
  always @(posedge ref_clk) begin
    if (rst) begin
      status_byte <= 8'h00;
    end else if (serial_poll) begin
      status_byte <= status_low;
      status_byte[`STB_SRQ_BIT] <= srq;
    end
  end
  // RL5 power-up sequence: the first cycle out of reset forces operate,
  // so a command racing the release cannot leave a calibration mode set
  always @* begin
    pwr_state_d = pwr_state_q;
    case (pwr_state_q)
      ST_BOOT: begin
        pwr_state_d = ST_RUN;
      end
      ST_RUN: begin
        pwr_state_d = ST_RUN;
      end
      default: begin
        pwr_state_d = ST_BOOT;
      end
    endcase
  end
  // RL6 sealed-system commands pick the mode; first command in a cycle wins
  // with the strap open the commands are ignored and the mode just holds
  always @* begin
    mode_d = mode;
    if (pwr_state_q != ST_RUN) begin
      mode_d = `MODE_OPERATE;
    end else if (sealed_system) begin
      if (operate_mode_cmd) begin
        mode_d = `MODE_OPERATE;
      end else if (dc_cal_mode_cmd) begin
        mode_d = `MODE_DC_CAL;
      end else if (ac_cal_mode_cmd) begin
        mode_d = `MODE_AC_CAL;
      end
    end
  end
  // RL5 RL6 mode and power-up state registers
  always @(posedge ref_clk) begin
    if (rst) begin
      mode <= `MODE_OPERATE;
      pwr_state_q <= ST_BOOT;
    end else begin
      mode <= mode_d;
      pwr_state_q <= pwr_state_d;
    end
  end
endmodule
`default_nettype wire

/* rtl/gpib_glue_map.vh */
`ifndef GPIB_GLUE_MAP_VH
`define GPIB_GLUE_MAP_VH
// address bits used by the latch/adapter select decode and the port select
`define A_BIT_SEL 6
`define A_BIT_P0 0
`define A_BIT_P1 1
`define A_BIT_P5 5
// port select code {a5,a1,a0}
`define PORT_CTRL 3'h1
`define PORT_DATA 3'h0
// status byte service request bit
`define STB_SRQ_BIT 6
// power-on clear hold time, ns
`define POR_NS 1000
`define CLK_NS 4
`define POR_CYC ((`POR_NS + `CLK_NS - 1) / `CLK_NS)
`define POR_W 9
// mode codes
`define MODE_OPERATE 2'h0
`define MODE_DC_CAL 2'h1
`define MODE_AC_CAL 2'h2
`endif

/* rtl/por_hold.v */
`timescale 1ns/10ps
`default_nettype none
`include "gpib_glue_map.vh"
module por_hold (
  input wire ref_clk,
  input wire rst,
  output wire adapter_reset_n
);
  reg [`POR_W-1:0] cnt_q;
  reg [`POR_W-1:0] cnt_d;
  // counter stands in for the rc charge time
  always @* begin
    cnt_d = cnt_q;
    if (cnt_q != `POR_CYC) begin
      cnt_d = cnt_q + 9'h001;
    end
  end
  always @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= 9'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign adapter_reset_n = (cnt_q == `POR_CYC);
endmodule
`default_nettype wire

/* verification/cpu_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none
// cpu strobes from request bits; idle address is scrambled, never held
module cpu_bus_model (
  input wire [3:0] req,
  input wire [7:0] a,
  output wire [7:0] cpu_addr,
  output wire rd_n,
  output wire wr_n,
  output wire cs_n,
  output wire prom_n
);
  assign cpu_addr = |req[2:0] ? a : ~a;
  assign {rd_n, wr_n, cs_n} = ~req[2:0];
  assign prom_n = ~req[3];
endmodule
`default_nettype wire

/* verification/glue_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
// decode and status relations at the glue pins
module glue_monitor (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] cpu_addr,
  input wire rd_n,
  input wire wr_n,
  input wire interface_chip_select_n,
  input wire serial_poll,
  input wire meas_done,
  input wire switch_latch_enable,
  input wire adapter_enable,
  input wire ctrl_port_sel,
  input wire buffer_transmit_enable,
  input wire [7:0] status_byte,
  input wire srq,
  input wire [15:0] reading
);
  wire cs = !interface_chip_select_n;
  wire a6 = cpu_addr[6];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence poll_s; serial_poll; endsequence
  a_latch_gate: assert property (switch_latch_enable == (!rd_n && cs && a6)) else $error("latch");
  a_adapter_gate: assert property (adapter_enable == (cs && !a6)) else $error("adapter");
  a_ctrl_port: assert property (ctrl_port_sel == (adapter_enable && {cpu_addr[5], cpu_addr[1], cpu_addr[0]} == 3'h1))
    else $error("port");
  a_tx_read: assert property (!rd_n |-> !buffer_transmit_enable) else $error("tx rd");
  a_tx_write: assert property (adapter_enable && !wr_n && rd_n |-> buffer_transmit_enable) else $error("tx wr");
  a_tx_idle: assert property (wr_n |-> !buffer_transmit_enable) else $error("tx idle");
  a_poll_bit: assert property (poll_s |=> status_byte[6] == $past(srq)) else $error("poll");
  a_reading_hold: assert property (!meas_done |=> $stable(reading)) else $error("hold");
endmodule
bind gpib_interface_glue glue_monitor mon_u (.*);
`default_nettype wire

/* verification/gpib_interface_glue_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module gpib_interface_glue_tb_top;
  typedef struct {int t; int k; logic [15:0] v;} note_t;
  note_t q[$], n;
  logic ref_clk = 0, rst = 1, sealed = 1, rd_n, wr_n, cs_n, prom_n, le, ae, cps, dps, te, arn, srq, mreq, g;
  logic h, poe, doe, ack;
  logic [2:0] pc;
  logic [3:0] req = 0;
  logic [7:0] a = 0, sw = 0, stl = 0, cpu_addr, data_out, status_byte;
  logic [9:0] p = 0;
  logic [15:0] mv = 0, reading;
  logic [31:0] w;
  logic [1:0] mode;
  int cyc = 0, errors = 0, total_checks = 0;
  cpu_bus_model cpu_u (.req(req), .a(a), .cpu_addr(cpu_addr), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .prom_n(prom_n));
  gpib_interface_glue dut_u (.ref_clk(ref_clk), .rst(rst), .cpu_addr(cpu_addr), .rd_n(rd_n), .wr_n(wr_n),
    .interface_chip_select_n(cs_n), .prom_enable_n(prom_n), .switch_bits(sw), .sealed_system(sealed),
    .meas_done(p[0]), .meas_value(mv), .trigger_cmd(p[1]), .hold_on_cmd(p[2]), .hold_off_cmd(p[3]),
    .meas_done_request_on_cmd(p[4]), .meas_done_request_off_cmd(p[5]), .operate_mode_cmd(p[6]),
    .dc_cal_mode_cmd(p[7]), .ac_cal_mode_cmd(p[8]), .serial_poll(p[9]), .status_low(stl),
    .prom_output_enable(poe), .switch_latch_enable(le), .adapter_enable(ae), .ctrl_port_sel(cps),
    .data_port_sel(dps), .buffer_transmit_enable(te), .adapter_reset_n(arn), .adapter_clk(ack),
    .data_out(data_out), .data_out_en(doe), .status_byte(status_byte), .srq(srq), .reading(reading),
    .meas_request(mreq), .mode(mode));
  // free-running clock, 4 ns period
  initial forever #2 ref_clk = ~ref_clk;
  // cycle count doubles as timeout
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      tally_and_finish;
    end
  end
  task chk(string s, logic [15:0] e, logic [15:0] v);
    total_checks++;
    if (v !== e) begin
      errors++;
      $display("[FAIL] %s exp %h seen %h", s, e, v);
    end
  endtask
  task note(int d, int k, logic [15:0] v);
    q.push_back('{cyc + d, k, v});
  endtask
  // one command word per cycle; zero word ends pulses
  task go(logic [9:0] pp, logic [15:0] v);
    @(posedge ref_clk);
    p <= pp;
    mv <= v;
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // compare just after each rising edge, while the clock is high and all settled
  always @(posedge ref_clk) begin
    #1;
    while (q.size() > 0 && q[0].t <= cyc) begin
      n = q.pop_front();
      case (n.k)
        0: chk("decode", n.v, {poe, doe, le, ae, cps, dps, te, ack});
        1: chk("srq", n.v, srq);
        2: chk("status", n.v, status_byte);
        3: chk("reading", n.v, reading);
        4: chk("mode", n.v, mode);
        5: chk("latch", n.v, data_out);
        6: chk("adapter_reset_n", n.v, arn);
        default: chk("meas_request", n.v, mreq);
      endcase
    end
  end
  initial begin
    void'($urandom(32'h67bd));
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    // other status bits without bit 6, so the poll must insert the flag
    stl <= 8'h1a;
    note(2, 6, 0);
    note(2, 4, 0);
    // adapter reset low for the whole charge count, high right after it
    repeat (249) @(posedge ref_clk);
    note(1, 6, 0);
    @(posedge ref_clk);
    note(1, 6, 1);
    repeat (40) begin
      @(posedge ref_clk);
      w = $urandom;
      req <= w[3:0];
      a <= w[11:4];
      sw <= w[19:12];
      g = w[0] & !w[10];
      h = w[2] & w[0] & w[10];
      pc = {w[9], w[5], w[4]};
      note(1, 0, {w[3], h, h, g, g && pc == 3'h1, g && pc == 3'h0, g & w[1] & !w[2], 1'b1});
      if (h) note(2, 5, w[19:12]);
    end
    go(10'h010, 0);
    go(10'h001, 16'h1234);
    note(2, 1, 1);
    note(2, 3, 16'h1234);
    go(10'h200, 0);
    note(2, 2, 8'h5a);
    note(2, 1, 0);
    go(10'h020, 0);
    // bit 6 set in the other status bits; the cleared flag must replace it
    stl <= 8'h5a;
    go(10'h001, 16'h0bad);
    note(2, 1, 0);
    go(10'h200, 0);
    note(2, 2, 8'h1a);
    go(10'h004, 0);
    go(10'h001, 16'h5555);
    note(2, 3, 16'h0bad);
    go(10'h003, 16'h7777);
    note(2, 3, 16'h7777);
    note(2, 7, 1);
    note(3, 7, 0);
    // pending trigger lets one more landing through, then hold bites again
    go(10'h001, 16'h4444);
    note(2, 3, 16'h4444);
    go(10'h001, 16'h2222);
    note(2, 3, 16'h4444);
    go(10'h008, 0);
    go(10'h001, 16'h3333);
    note(2, 3, 16'h3333);
    go(10'h080, 0);
    note(2, 4, 1);
    go(10'h100, 0);
    note(2, 4, 2);
    go(10'h040, 0);
    note(2, 4, 0);
    go(10'h100, 0);
    sealed <= 0;
    note(2, 4, 0);
    // mid-run reset; a mode command in the first cycle after it is ignored
    go(0, 0);
    sealed <= 1;
    rst <= 1;
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    p <= 10'h080;
    note(2, 4, 0);
    note(2, 6, 0);
    note(2, 1, 0);
    note(2, 3, 0);
    go(0, 0);
    repeat (4) @(posedge ref_clk);
    tally_and_finish;
  end
endmodule
`default_nettype wire
